// File: hw/anadv_pkg.sv
/*
 holds constants and the carrier type for the advertisement register bank.
 assumes a management access port (address, write data, strobes) decoded upstream of the serial frame.
*/
// Function
// - revision code sits in identifier register low nibble
// - link code word built from advertisement when enabled
// - next-page bit read/write, resets to zero
// - reserved bits always read back as zero
// - override-gated bits written only with override set
// - remote-fault bit follows local link fault
// - ability bit one means technology supported
// - four-pair 100 Mb/s ability always zero
// - four ability bits default one when negotiating
// - ability defaults follow config pin and enable
// - negotiation disabled: sequencer sends idle
// - status capability bits never follow advertisement
// - selector defaults to 802.3 code, transmitted
package anadv_pkg;
	localparam logic [4:0]  ADDR_ADVERT     = 5'h04;
	localparam logic [4:0]  ADDR_ID2        = 5'h03;
	localparam logic [15:0] ID2_UPPER       = 16'h0000; // arbitrary value, upper identifier bits
	localparam logic [3:0]  REVISION_CODE   = 4'h5;     // arbitrary value
	localparam int          BIT_NEXT_PAGE   = 15;
	localparam int          BIT_ACK         = 14;
	localparam int          BIT_REM_FAULT   = 13;
	localparam int          BIT_T4          = 9;
	localparam logic [15:0] RSVD_MASK       = 16'h5c00; // bits 14, 12:10
	localparam logic [15:0] CW_MASK         = 16'h5e1f; // reserved, t4, selector
	localparam logic [3:0]  ABIL_DEFAULT_AN = 4'hf;
	localparam logic [3:0]  ABIL_DEFAULT_NO = 4'h0;
	localparam logic [4:0]  SELECTOR_8023   = 5'h01;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} anadv_mgmt_s;
endpackage : anadv_pkg

// File: hw/anadv_regs.sv
/*
 advertisement register bank with revision field of the second identifier register.
 assumes management strobes synchronous to ref_clk, one cycle each.
*/
`timescale 1ns/1ps
module anadv_regs
	import anadv_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire anadv_mgmt_s mgmt,
	input  wire logic        cmd_override,
	input  wire logic        an_enable,
	input  wire logic        config_select_pin_a,
	input  wire logic        link_fault,
	input  wire logic        an_restart,
	output logic [15:0]      rdata_q,
	output logic [15:0]      link_code_word_q,
	output logic             send_idle,
	output logic             lcw_load
);
	typedef enum logic [1:0] {ST_INIT = 2'b00, ST_NEG = 2'b01, ST_IDLE = 2'b10} anadv_st_e;

	logic [15:0] adv_q, adv_d;
	logic        init_q;
	anadv_st_e   st_q, st_d;
	logic [3:0]  abil_default;

	// write decode; rw bits always, gated bits only under override
	wire wr_adv = mgmt.wr && (mgmt.addr == ADDR_ADVERT);
	wire [15:0] wr_mask = cmd_override ? 16'hffff : ~CW_MASK;
	// ability defaults chosen by config pin and negotiation enable
	assign abil_default = (an_enable || !config_select_pin_a) ? ABIL_DEFAULT_AN : ABIL_DEFAULT_NO;

	// storage next value; fault bit tracks the line, t4 forced low
	always_comb
	begin
		adv_d = adv_q;
		if (init_q)
			adv_d[8:5] = abil_default;
		if (wr_adv)
			adv_d = (adv_q & ~wr_mask) | (mgmt.wdata & wr_mask);
		adv_d[BIT_REM_FAULT] = link_fault;
		adv_d[BIT_T4]        = 1'b0;
	end

	// register; defaults are known after reset, pin taken one edge later
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			adv_q  <= {11'h000, SELECTOR_8023};
			init_q <= 1'b1;
		end
		else
		begin
			adv_q  <= adv_d;
			init_q <= 1'b0;
		end
	end

	// reserved bits always read zero whatever got stored
	wire [15:0] adv_rd = adv_q & ~RSVD_MASK;
	wire [15:0] id2_rd = {ID2_UPPER[15:4], REVISION_CODE};

	// read data registered; status capability lives elsewhere, untouched here
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= 16'h0000;
		else if (mgmt.rd)
			rdata_q <= (mgmt.addr == ADDR_ADVERT) ? adv_rd : (mgmt.addr == ADDR_ID2) ? id2_rd : 16'h0000;
	end

	// sequencer: negotiate when enabled, otherwise fall to idle
	always_comb
	begin
		case (st_q)
			ST_INIT: st_d = an_enable ? ST_NEG : ST_IDLE;
			ST_NEG:  st_d = an_enable ? ST_NEG : ST_IDLE;
			ST_IDLE: st_d = an_enable ? ST_NEG : ST_IDLE;
			default: st_d = ST_INIT;
		endcase
	end
	assign send_idle = (st_q == ST_IDLE);
	// load strobe is the very condition that captures the code word below
	assign lcw_load  = (st_d == ST_NEG) && (st_q != ST_NEG || an_restart);

	// code word captured on entry to negotiation or restart, reserved bits cleared
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q             <= ST_INIT;
			link_code_word_q <= 16'h0000;
		end
		else
		begin
			st_q <= st_d;
			if (st_d == ST_NEG && (st_q != ST_NEG || an_restart))
				link_code_word_q <= adv_d & ~RSVD_MASK;
		end
	end

	AST_RESV_ZERO: assert property (@(posedge ref_clk) disable iff (!nrst)
		mgmt.rd && mgmt.addr == ADDR_ADVERT |=> (rdata_q & RSVD_MASK) == 16'h0000)
		else $error("reserved bits read nonzero");
	AST_GATED: assert property (@(posedge ref_clk) disable iff (!nrst)
		wr_adv && !cmd_override |=> (adv_q & CW_MASK) == ($past(adv_q) & CW_MASK))
		else $error("gated bit changed without override");
	AST_FAULT: assert property (@(posedge ref_clk) disable iff (!nrst)
		##1 adv_q[BIT_REM_FAULT] == $past(link_fault))
		else $error("fault bit does not follow link");
	AST_T4: assert property (@(posedge ref_clk) disable iff (!nrst) ##1 !adv_q[BIT_T4])
		else $error("t4 ability set");
	AST_IDLE: assert property (@(posedge ref_clk) disable iff (!nrst)
		!an_enable ##1 !an_enable |-> send_idle)
		else $error("idle not entered");
	AST_REV: assert property (@(posedge ref_clk) disable iff (!nrst)
		mgmt.rd && mgmt.addr == ADDR_ID2 |=> rdata_q[3:0] == REVISION_CODE)
		else $error("revision wrong");
	AST_LCW: assert property (@(posedge ref_clk) disable iff (!nrst)
		st_q != ST_NEG && st_d == ST_NEG |=> link_code_word_q == (adv_q & ~RSVD_MASK))
		else $error("code word mismatch");
	AST_NP: assert property (@(posedge ref_clk) disable iff (!nrst)
		wr_adv |=> adv_q[BIT_NEXT_PAGE] == $past(mgmt.wdata[BIT_NEXT_PAGE]))
		else $error("next page not written");

	// building blocks for the multi-step checks below
	sequence seq_neg_entry;
		st_q != ST_NEG && st_d == ST_NEG;
	endsequence

	sequence seq_restart_req;
		st_q == ST_NEG && an_enable && an_restart;
	endsequence

	sequence seq_id2_read;
		mgmt.rd && mgmt.addr == ADDR_ID2;
	endsequence

	sequence seq_unmapped_read;
		mgmt.rd && mgmt.addr != ADDR_ADVERT && mgmt.addr != ADDR_ID2;
	endsequence

	sequence seq_idle_hold;
		!an_enable ##1 !an_enable;
	endsequence

	// code word follows the register on restart, and only then or on entry
	AST_RESTART_LCW: assert property (@(posedge ref_clk) disable iff (!nrst)
		seq_restart_req |=> link_code_word_q == (adv_q & ~RSVD_MASK))
		else $error("code word not reloaded on restart");

	AST_LCW_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		!lcw_load |=> $stable(link_code_word_q))
		else $error("code word moved without load");

	AST_LOAD_ENTRY: assert property (@(posedge ref_clk) disable iff (!nrst)
		seq_neg_entry |-> lcw_load)
		else $error("no load on negotiation entry");

	// read path: unmapped addresses give zero, data stands until next read
	AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!nrst)
		seq_unmapped_read |=> rdata_q == 16'h0000)
		else $error("unmapped read nonzero");

	AST_RDATA_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		!mgmt.rd |=> $stable(rdata_q))
		else $error("read data moved without read");

	AST_REV_WORD: assert property (@(posedge ref_clk) disable iff (!nrst)
		seq_id2_read |=> rdata_q[15:4] == ID2_UPPER[15:4])
		else $error("identifier upper bits wrong");

	// write path: selector stays put unless override, abilities always writable
	AST_SEL_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		!cmd_override |=> adv_q[4:0] == $past(adv_q[4:0]))
		else $error("selector changed without override");

	AST_ABIL_WRITE: assert property (@(posedge ref_clk) disable iff (!nrst)
		wr_adv |=> adv_q[8:5] == $past(mgmt.wdata[8:5]))
		else $error("ability bits not written");

	AST_OVR_WRITE: assert property (@(posedge ref_clk) disable iff (!nrst)
		wr_adv && cmd_override |=> (adv_q & RSVD_MASK) == ($past(mgmt.wdata) & RSVD_MASK))
		else $error("reserved bits not written under override");

	// sequencer leaves idle as soon as negotiation is enabled again
	AST_NOT_IDLE: assert property (@(posedge ref_clk) disable iff (!nrst)
		an_enable |=> !send_idle)
		else $error("idle while negotiating");

	AST_IDLE_SEQ: assert property (@(posedge ref_clk) disable iff (!nrst)
		seq_idle_hold |-> send_idle)
		else $error("idle not held while disabled");
endmodule : anadv_regs

// File: verification/anadv_sta_model.sv
/*
 management station model: one-cycle read and write strobes on the access port.
 assumes rdata_q settles one cycle after the read strobe is taken.
*/
`timescale 1ns/1ps
module anadv_sta_model
	import anadv_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic [15:0] rdata_q,
	output anadv_mgmt_s      mgmt
);
	initial mgmt = '0;

	// one strobe cycle, then release with inverted bus so stale values never look valid
	task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] wdata, output logic [15:0] rdata);
		@(posedge ref_clk);
		mgmt <= '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
		@(posedge ref_clk);
		mgmt <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
		@(negedge ref_clk);
		rdata = rdata_q;
	endtask : access
endmodule : anadv_sta_model

// File: verification/testbench.sv
/*
 self-checking bench for the advertisement register bank.
 assumes the station model drives the access port; configuration pin driven by the bench.
*/
`timescale 1ns/1ps
module testbench import anadv_pkg::*;;
	logic        ref_clk, nrst, cmd_override, an_enable, link_fault, an_restart, send_idle;
	logic [15:0] rdata_q, lcw, rd;
	logic        cfg_pin, ld;
	anadv_mgmt_s mgmt;
	int          n_errors, num_checks, cycles;

	anadv_regs i_anadv_regs (.ref_clk(ref_clk), .nrst(nrst), .mgmt(mgmt), .cmd_override(cmd_override),
		.an_enable(an_enable), .config_select_pin_a(cfg_pin), .link_fault(link_fault), .an_restart(an_restart),
		.rdata_q(rdata_q), .link_code_word_q(lcw), .send_idle(send_idle), .lcw_load(ld));
	anadv_sta_model i_anadv_sta_model (.ref_clk(ref_clk), .rdata_q(rdata_q), .mgmt(mgmt));

	// compare and count
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// hang guard: the whole sequence needs well under a hundred cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end

	initial
	begin
		{nrst, cmd_override, link_fault, an_restart} = 4'h0;
		an_enable = 1'b1;
		cfg_pin = 1'b0;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		i_anadv_sta_model.access(1'b0, ADDR_ADVERT, 16'h0000, rd);
		chk("adv_reset", rd, 16'h01e1);
		i_anadv_sta_model.access(1'b0, ADDR_ID2, 16'h0000, rd);
		chk("revision", {12'h000, rd[3:0]}, {12'h000, REVISION_CODE});
		i_anadv_sta_model.access(1'b0, 5'h1f, 16'h0000, rd);
		chk("unmapped", rd, 16'h0000);
		$display("test reset_values done");
		// reserved bits written at their default; gated bits must not move yet
		i_anadv_sta_model.access(1'b1, ADDR_ADVERT, 16'h821e, rd);
		i_anadv_sta_model.access(1'b0, ADDR_ADVERT, 16'h0000, rd);
		chk("adv_gated_off", rd, 16'h8001);
		@(posedge ref_clk) cmd_override <= 1'b1;
		i_anadv_sta_model.access(1'b1, ADDR_ADVERT, 16'h7e1f, rd);
		i_anadv_sta_model.access(1'b0, ADDR_ADVERT, 16'h0000, rd);
		chk("adv_gated_on", rd, 16'h001f);
		$display("test override_gating done");
		@(posedge ref_clk) link_fault <= 1'b1;
		i_anadv_sta_model.access(1'b0, ADDR_ADVERT, 16'h0000, rd);
		chk("remote_fault", rd, 16'h201f);
		@(posedge ref_clk) an_restart <= 1'b1;
		@(negedge ref_clk) chk("lcw_load", {15'h0000, ld}, 16'h0001);
		@(posedge ref_clk) an_restart <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk("code_word", lcw & ~RSVD_MASK, 16'h201f);
		@(posedge ref_clk) an_enable <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("idle", {15'h0000, send_idle}, 16'h0001);
		$display("test code_word done");
		// mid-run reset with pin high and negotiation off: abilities default to zero
		@(posedge ref_clk) nrst <= 1'b0;
		cfg_pin <= 1'b1;
		link_fault <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		i_anadv_sta_model.access(1'b0, ADDR_ADVERT, 16'h0000, rd);
		chk("adv_pin_high", rd, 16'h0001);
		chk("idle_after_reset", {15'h0000, send_idle}, 16'h0001);
		$display("test pin_default done");
		tally_and_finish();
	end
endmodule : testbench
